// File: include/csc_pkg.sv
package csc_pkg;
	// Bus widths
	localparam int APB_AW = 16;
	localparam int APB_DW = 32;
	localparam int REG_W  = 16;

	// Register indices; byte address is four times the index
	localparam logic [15:0] IDX_CAM1_POL   = 16'h2002;
	localparam logic [15:0] IDX_CAM2_POL   = 16'h2006;
	localparam logic [15:0] IDX_CAM_MODE   = 16'h2010;
	localparam logic [15:0] IDX_CAP_MODE   = 16'h2012;
	localparam logic [15:0] IDX_CAP_CMD    = 16'h2014;
	localparam logic [15:0] IDX_LINE_DLY   = 16'h2020;
	localparam logic [15:0] IDX_PULSE_W    = 16'h2022;
	localparam logic [15:0] IDX_STB_CTRL   = 16'h2024;
	localparam logic [15:0] IDX_IRQ_STAT   = 16'h2030;
	localparam logic [15:0] IDX_IRQ_MASK   = 16'h2032;

	// Reset value of every register
	localparam logic [15:0] REG_RST        = 16'h0000;

	// Field positions
	localparam int POL_LINE_BIT    = 0;
	localparam int POL_FRAME_BIT   = 1;
	localparam int MODE_BT656_BIT  = 7;
	localparam int CAPM_EN_BIT     = 0;
	localparam int CAPM_PORT_BIT   = 1;
	localparam int CAPM_SINGLE_BIT = 6;
	localparam int CMD_RUN_BIT     = 0;
	localparam int CMD_BUSY_BIT    = 1;
	localparam int CMD_START_BIT   = 2;
	localparam int CMD_STOP_BIT    = 3;
	localparam int STB_POL_BIT     = 1;
	localparam int STB_ALIGN_BIT   = 2;
	localparam int STB_CDLY_LSB    = 4;
	localparam int STB_CDLY_MSB    = 7;
	localparam int IRQ_DONE_BIT    = 0;
	localparam int IRQ_STB_BIT     = 1;
	localparam int IRQ_W           = 2;

	// Pin sampler depth and pin count
	localparam int SYNC_STAGES     = 2;
	localparam int SYNC_PINS       = 4;

	typedef enum logic [2:0]
	{
		ST_IDLE  = 3'b000,
		ST_ARM   = 3'b001,
		ST_DELAY = 3'b010,
		ST_PULSE = 3'b011,
		ST_SKIP  = 3'b100,
		ST_LAST  = 3'b101
	} csc_state_e;
endpackage

// File: include/csc_sync_if.sv
`timescale 1ns/100ps
interface csc_sync_if #(parameter int N = 4);
	logic [N-1:0] raw;
	logic [N-1:0] synced;
	modport sync (input raw, output synced);
	modport user (output raw, input synced);
endinterface

// File: logic/csc_sync.sv
`timescale 1ns/100ps
module csc_sync
(
	input wire logic    pclk,    // System clock
	input wire logic    presetn, // Async reset, active low
	csc_sync_if.sync    sif      // Raw pins in, synced levels out
);
	import csc_pkg::*;

	logic [SYNC_PINS-1:0] stage1;
	logic [SYNC_PINS-1:0] stage2;

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			stage1 <= '0;
			stage2 <= '0;
		end
		else
		begin
			stage1 <= sif.raw;
			stage2 <= stage1;
		end
	end

	assign sif.synced = stage2;
endmodule

// File: logic/csc_top.sv
// Summary of operation
// - Strobe triggers act only while the camera interface is enabled.
// - Continuous mode: writing one to stop bit starts strobe sequence.
// - Continuous mode: capture delay field picks how many frames later capture ends.
// - Single-frame mode: writing one to start bit starts strobe sequence.
// - Single-frame mode captures the frame right after the pulse.
// - Strobe asserts on line-ref falling edge chosen by line delay.
// - Line delay zero asserts on first falling edge after frame ref.
// - Delay and width count line-ref edges; counting pauses with them.
// - Counts may exceed a frame period and run across frames.
// - Strobe active level comes from strobe control active select.
// - Frame capture completion raises an interrupt.
// - Capture-done interrupt can be aligned to the strobe sequence.
// - Frame ref is active low when port active select is cleared.
//
// Decided for this implementation: the APB interface to the registers.
`timescale 1ns/100ps
module csc_top
(
	input  wire logic                        pclk,            // Clock
	input  wire logic                        presetn,         // Reset, low
	input  wire logic                        psel,            // APB select
	input  wire logic                        penable,         // APB enable
	input  wire logic                        pwrite,          // APB write
	input  wire logic [csc_pkg::APB_AW-1:0]  paddr,           // APB address
	input  wire logic [csc_pkg::APB_DW-1:0]  pwdata,          // APB wdata
	output logic      [csc_pkg::APB_DW-1:0]  prdata,          // APB rdata
	output logic                             pready,          // APB ready
	output logic                             pslverr,         // APB error
	input  wire logic                        port1_frame_ref, // Port 1 vref
	input  wire logic                        port1_line_ref,  // Port 1 href
	input  wire logic                        port2_frame_ref, // Port 2 vref
	input  wire logic                        port2_line_ref,  // Port 2 href
	output logic                             flash_pulse_out, // Strobe pin
	output logic                             capture_valid,   // Frame taken
	output logic                             irq              // Interrupt
);
	import csc_pkg::*;

	function automatic logic [APB_AW-1:0] byte_addr(input logic [15:0] idx);
		byte_addr = {idx[APB_AW-3:0], 2'b00};
	endfunction

	function automatic logic is_mapped(input logic [APB_AW-1:0] a);
		is_mapped = (a == byte_addr(IDX_CAM1_POL)) ||
			(a == byte_addr(IDX_CAM2_POL)) ||
			(a == byte_addr(IDX_CAM_MODE)) ||
			(a == byte_addr(IDX_CAP_MODE)) ||
			(a == byte_addr(IDX_CAP_CMD)) ||
			(a == byte_addr(IDX_LINE_DLY)) ||
			(a == byte_addr(IDX_PULSE_W)) ||
			(a == byte_addr(IDX_STB_CTRL)) ||
			(a == byte_addr(IDX_IRQ_STAT)) ||
			(a == byte_addr(IDX_IRQ_MASK));
	endfunction

	// Registers
	logic [REG_W-1:0]  camera1_sync_polarity;
	logic [REG_W-1:0]  camera2_sync_polarity;
	logic [REG_W-1:0]  camera_mode_setting;
	logic [REG_W-1:0]  capture_mode_control;
	logic [REG_W-1:0]  strobe_line_delay;
	logic [REG_W-1:0]  strobe_pulse_width;
	logic [REG_W-1:0]  strobe_control;
	logic [IRQ_W-1:0]  irq_status;
	logic [IRQ_W-1:0]  irq_mask;
	logic [IRQ_W-1:0]  irq_reported;

	// Sequencer state
	csc_state_e        state;
	logic [REG_W-1:0]  line_cnt;
	logic [3:0]        frames_left;
	logic              strobe_on;
	logic              cap_run;
	logic              frame_prev;
	logic              line_prev;

	// Combinational
	logic [REG_W-1:0]  rd_val;
	logic              wr_acc;
	logic              rd_acc;
	logic              cmd_wr;
	logic              cam_en;
	logic              single;
	logic              port_sel;
	logic [REG_W-1:0]  pol_sel;
	logic              frame_act;
	logic              line_act;
	logic              frame_rise;
	logic              frame_fall;
	logic              line_fall;
	logic              stop_trig;
	logic              start_trig;
	logic              pulse_end;
	logic              frame_done;
	logic              last_done;
	logic [IRQ_W-1:0]  irq_set;
	logic [REG_W:0]    width_next;

	csc_sync_if #(.N(SYNC_PINS)) sif ();

	assign sif.raw = {port2_line_ref, port2_frame_ref,
		port1_line_ref, port1_frame_ref};

	csc_sync u_sync
	(
		.pclk    (pclk),
		.presetn (presetn),
		.sif     (sif)
	);

	assign cam_en   = capture_mode_control[CAPM_EN_BIT];
	assign single   = capture_mode_control[CAPM_SINGLE_BIT];
	assign port_sel = capture_mode_control[CAPM_PORT_BIT];
	assign pol_sel  = port_sel ? camera2_sync_polarity
		: camera1_sync_polarity;

	// Active levels after polarity select of the chosen port
	assign frame_act = (port_sel ? sif.synced[2] : sif.synced[0]) ~^
		pol_sel[POL_FRAME_BIT];
	assign line_act  = (port_sel ? sif.synced[3] : sif.synced[1]) ~^
		pol_sel[POL_LINE_BIT];

	assign frame_rise = frame_act & ~frame_prev;
	assign frame_fall = ~frame_act & frame_prev;
	assign line_fall  = ~line_act & line_prev;

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			frame_prev <= 1'b0;
			line_prev  <= 1'b0;
		end
		else
		begin
			frame_prev <= frame_act;
			line_prev  <= line_act;
		end
	end

	// APB handshake: one wait-free access phase
	assign wr_acc = psel & penable & pready & pwrite;
	assign rd_acc = psel & penable & pready & ~pwrite;
	assign cmd_wr = wr_acc & (paddr == byte_addr(IDX_CAP_CMD));

	assign stop_trig  = cmd_wr & pwdata[CMD_STOP_BIT] & cam_en &
		~single & (state == ST_IDLE);
	assign start_trig = cmd_wr & pwdata[CMD_START_BIT] & cam_en &
		single & (state == ST_IDLE);

	always_comb
	begin
		rd_val = '0;
		case (paddr)
			byte_addr(IDX_CAM1_POL): rd_val = camera1_sync_polarity;
			byte_addr(IDX_CAM2_POL): rd_val = camera2_sync_polarity;
			byte_addr(IDX_CAM_MODE): rd_val = camera_mode_setting;
			byte_addr(IDX_CAP_MODE): rd_val = capture_mode_control;
			byte_addr(IDX_CAP_CMD):
			begin
				rd_val[CMD_RUN_BIT]  = cap_run;
				rd_val[CMD_BUSY_BIT] = (state != ST_IDLE);
			end
			byte_addr(IDX_LINE_DLY): rd_val = strobe_line_delay;
			byte_addr(IDX_PULSE_W):  rd_val = strobe_pulse_width;
			byte_addr(IDX_STB_CTRL): rd_val = strobe_control;
			byte_addr(IDX_IRQ_STAT): rd_val[IRQ_W-1:0] = irq_status;
			byte_addr(IDX_IRQ_MASK): rd_val[IRQ_W-1:0] = irq_mask;
			default:                 rd_val = '0;
		endcase
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			pready       <= 1'b0;
			pslverr      <= 1'b0;
			prdata       <= '0;
			irq_reported <= '0;
		end
		else
		begin
			pready  <= psel & ~penable;
			pslverr <= psel & ~penable & ~is_mapped(paddr);
			if (psel & ~penable)
			begin
				prdata       <= {{(APB_DW-REG_W){1'b0}}, rd_val};
				irq_reported <= (paddr == byte_addr(IDX_IRQ_STAT))
					? irq_status : '0;
			end
		end
	end

	// Software-written registers
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			camera1_sync_polarity <= REG_RST;
			camera2_sync_polarity <= REG_RST;
			camera_mode_setting   <= REG_RST;
			capture_mode_control  <= REG_RST;
			strobe_line_delay     <= REG_RST;
			strobe_pulse_width    <= REG_RST;
			strobe_control        <= REG_RST;
			irq_mask              <= '0;
		end
		else if (wr_acc)
		begin
			case (paddr)
				byte_addr(IDX_CAM1_POL):
					camera1_sync_polarity <= pwdata[REG_W-1:0];
				byte_addr(IDX_CAM2_POL):
					camera2_sync_polarity <= pwdata[REG_W-1:0];
				byte_addr(IDX_CAM_MODE):
					camera_mode_setting <= pwdata[REG_W-1:0];
				byte_addr(IDX_CAP_MODE):
					capture_mode_control <= pwdata[REG_W-1:0];
				byte_addr(IDX_LINE_DLY):
					strobe_line_delay <= pwdata[REG_W-1:0];
				byte_addr(IDX_PULSE_W):
					strobe_pulse_width <= pwdata[REG_W-1:0];
				byte_addr(IDX_STB_CTRL):
					strobe_control <= pwdata[REG_W-1:0];
				byte_addr(IDX_IRQ_MASK):
					irq_mask <= pwdata[IRQ_W-1:0];
				default:
					irq_mask <= irq_mask;
			endcase
		end
	end

	// Width zero behaves as one edge
	assign width_next = {1'b0, line_cnt} + {{REG_W{1'b0}}, 1'b1};
	assign pulse_end  = (state == ST_PULSE) & line_fall &
		(width_next >= {1'b0, strobe_pulse_width});

	// Strobe sequencer
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			state       <= ST_IDLE;
			line_cnt    <= '0;
			frames_left <= '0;
			strobe_on   <= 1'b0;
		end
		else if (!cam_en)
		begin
			state     <= ST_IDLE;
			strobe_on <= 1'b0;
		end
		else
		begin
			case (state)
				ST_IDLE:
				begin
					if (stop_trig | start_trig)
						state <= ST_ARM;
				end
				ST_ARM:
				begin
					if (frame_rise)
					begin
						state    <= ST_DELAY;
						line_cnt <= '0;
					end
				end
				ST_DELAY:
				begin
					// Frame edges do not restart the count
					if (line_fall)
					begin
						if (line_cnt == strobe_line_delay)
						begin
							state     <= ST_PULSE;
							strobe_on <= 1'b1;
							line_cnt  <= '0;
						end
						else
							line_cnt <= line_cnt + 16'h0001;
					end
				end
				ST_PULSE:
				begin
					if (pulse_end)
					begin
						strobe_on <= 1'b0;
						state     <= ST_SKIP;
						frames_left <= single ? 4'h0
							: strobe_control[STB_CDLY_MSB:STB_CDLY_LSB];
					end
					else if (line_fall)
						line_cnt <= line_cnt + 16'h0001;
				end
				ST_SKIP:
				begin
					if (frame_rise)
					begin
						if (frames_left == 4'h0)
							state <= ST_LAST;
						else
							frames_left <= frames_left - 4'h1;
					end
				end
				ST_LAST:
				begin
					if (frame_fall)
						state <= ST_IDLE;
				end
				default:
					state <= ST_IDLE;
			endcase
		end
	end

	// Continuous capture runs from start until the last frame ends
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			cap_run <= 1'b0;
		else if (!cam_en | last_done)
			cap_run <= 1'b0;
		else if (cmd_wr & pwdata[CMD_START_BIT] & ~single)
			cap_run <= 1'b1;
	end

	assign frame_done = frame_fall & (cap_run | (state == ST_LAST));
	assign last_done  = frame_fall & (state == ST_LAST) & cam_en;

	// Align selects: every captured frame or only the sequence's final frame
	assign irq_set[IRQ_DONE_BIT] = strobe_control[STB_ALIGN_BIT]
		? last_done : frame_done;
	assign irq_set[IRQ_STB_BIT]  = pulse_end;

	// Read clears only bits returned; a new event wins
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			irq_status <= '0;
		else
			irq_status <= (irq_status &
				~(rd_acc ? irq_reported : {IRQ_W{1'b0}})) | irq_set;
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			flash_pulse_out <= 1'b1;
			capture_valid   <= 1'b0;
			irq             <= 1'b0;
		end
		else
		begin
			flash_pulse_out <= strobe_on ~^
				strobe_control[STB_POL_BIT];
			capture_valid   <= frame_act & cam_en &
				(cap_run | (state == ST_LAST));
			irq             <= |(irq_status & irq_mask);
		end
	end
endmodule

// File: test/csc_checker.sv
`timescale 1ns/100ps
module csc_checker
(
	input wire logic                       pclk,            // Clock
	input wire logic                       presetn,         // Reset, low
	input wire logic                       psel,            // Select
	input wire logic                       penable,         // Enable
	input wire logic                       pwrite,          // Write
	input wire logic [csc_pkg::APB_AW-1:0] paddr,           // Address
	input wire logic [csc_pkg::APB_DW-1:0] prdata,          // Read data
	input wire logic                       pready,          // Ready
	input wire logic                       pslverr,         // Error
	input wire logic                       port1_line_ref,  // Line pin
	input wire logic                       port1_frame_ref, // Frame pin
	input wire logic                       flash_pulse_out, // Strobe pin
	input wire logic                       capture_valid,   // Frame taken
	input wire logic                       irq              // Interrupt
);
	import csc_pkg::*;
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);
	logic [3:0] since_l;
	logic [3:0] since_f;
	logic [3:0] since_w;
	logic [3:0] since_a;
	// Cycles since last pin change or bus access, saturating
	always_ff @(posedge pclk or negedge presetn)
		if (!presetn)
		begin
			since_l <= '0;
			since_f <= '0;
			since_w <= '0;
			since_a <= '0;
		end
		else
		begin
			since_l <= $changed(port1_line_ref) ? '0
				: since_l + {3'h0, since_l != 4'hf};
			since_f <= $changed(port1_frame_ref) ? '0
				: since_f + {3'h0, since_f != 4'hf};
			since_w <= (psel && penable && pwrite) ? '0
				: since_w + {3'h0, since_w != 4'hf};
			since_a <= (psel && penable && pready) ? '0
				: since_a + {3'h0, since_a != 4'hf};
		end
	sequence s_setup;
		psel && !penable;
	endsequence
	chk_ready_setup: assert property (s_setup |=> pready)
		else $error("no ready after setup");
	chk_ready_once: assert property (pready |=> !pready)
		else $error("ready held too long");
	chk_err_ready: assert property (pslverr |-> pready)
		else $error("error without ready");
	chk_err_unmap: assert property (s_setup ##0 paddr == 16'h0004
		|=> pslverr && prdata == '0)
		else $error("unmapped access not refused");
	chk_rdata_high: assert property (pready |-> prdata[31:16] == 16'h0)
		else $error("upper read data not zero");
	chk_strobe_line: assert property ($changed(flash_pulse_out)
		|-> since_l <= 4'd8 || since_w <= 4'd4)
		else $error("strobe moved away from line edge");
	chk_irq_fall: assert property ($fell(irq) |-> since_a <= 4'd3)
		else $error("irq fell without access");
	chk_cap_frame: assert property ($rose(capture_valid)
		|-> since_f <= 4'd8 || since_w <= 4'd4)
		else $error("capture began away from frame edge");
endmodule
bind csc_top csc_checker chk
(
	.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
	.pwrite(pwrite), .paddr(paddr), .prdata(prdata), .pready(pready),
	.pslverr(pslverr), .port1_line_ref(port1_line_ref),
	.port1_frame_ref(port1_frame_ref), .flash_pulse_out(flash_pulse_out),
	.capture_valid(capture_valid), .irq(irq)
);

// File: test/csc_cam_model.sv
`timescale 1ns/100ps
module csc_cam_model
(
	input wire logic run,       // Generate syncs
	input wire logic inv,       // Pins active low
	output logic     frame_ref, // Frame pin
	output logic     line_ref   // Line pin
);
	logic f = 0;
	logic l = 0;
	assign frame_ref = f ^ inv;
	assign line_ref = l ^ inv;
	// Eight 32 ns lines a frame; first line holds the frame pulse
	initial
		forever
			for (int i = 0; i < 8; i++)
			begin
				wait (run);
				#8 f = (i == 0);
				#8 l = (i != 0);
				#16 l = 0;
			end
endmodule

// File: test/tb_top.sv
`timescale 1ns/100ps
module tb_top;
	import csc_pkg::*;
	logic        pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
	logic [15:0] paddr = '0;
	logic [31:0] pwdata = '0, prdata, rd;
	logic        pready, pslverr, fl, cv, irq, fr, lr, err;
	logic        run = 1, inv = 0, spol = 1, arm = 0;
	int          n_fail = 0, n_tests = 0, lcnt, dseen, wcnt, ncap, nw;
	logic [15:0] regs [10] = '{IDX_CAM1_POL, IDX_CAM2_POL, IDX_CAM_MODE,
		IDX_CAP_MODE, IDX_CAP_CMD, IDX_LINE_DLY, IDX_PULSE_W, IDX_STB_CTRL,
		IDX_IRQ_STAT, IDX_IRQ_MASK};
	wire         sact = (fl === spol);
	always #2 pclk = ~pclk;
	csc_cam_model cam (.run(run), .inv(inv), .frame_ref(fr), .line_ref(lr));
	csc_top dut (.pclk(pclk), .presetn(presetn), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
		.prdata(prdata), .pready(pready), .pslverr(pslverr),
		.port1_frame_ref(fr), .port1_line_ref(lr), .port2_frame_ref(fr),
		.port2_line_ref(lr), .flash_pulse_out(fl), .capture_valid(cv),
		.irq(irq));
	// Line edges since the armed frame, and while the strobe is on
	always @(negedge cam.l)
	begin
		lcnt++;
		if (sact) wcnt++;
	end
	always @(posedge cam.f)
		if (arm)
		begin
			arm = 0;
			lcnt = 0;
		end
	always @(posedge sact) dseen = lcnt;
	always @(negedge sact) ncap = 0;
	always @(negedge cv) ncap++;
	task automatic chk(input logic [31:0] s, e);
		n_tests++;
		if (s !== e)
		begin
			n_fail++;
			$display("CHECK FAILED %0t seen %h expected %h", $time, s, e);
		end
	endtask
	task automatic complete_run;
		if (n_fail == 0 && n_tests > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask
	task automatic tmo(input int n);
		if (n >= 4000)
		begin
			n_fail++;
			complete_run;
		end
	endtask
	task automatic bus(input logic wr, input logic [15:0] i, d);
		int n;
		@(posedge pclk);
		psel <= 1;
		penable <= 0;
		pwrite <= wr;
		paddr <= {i[13:0], 2'b00};
		pwdata <= {16'h0, d};
		@(posedge pclk);
		penable <= 1;
		for (n = 0; n == 0 || (pready !== 1'b1 && n < 4000); n++)
			@(posedge pclk);
		rd = prdata;
		err = pslverr;
		psel <= 0;
		penable <= 0;
		tmo(n);
	endtask
	task automatic w(input logic [15:0] i, d);
		bus(1, i, d);
	endtask
	task automatic r(input logic [15:0] i, e);
		bus(0, i, 16'h0);
		chk(rd, {16'h0, e});
	endtask
	task automatic strobe(input logic sg, p, input logic [15:0] dl, wd,
		input logic [3:0] cd, input logic pz);
		int n;
		inv = !p;
		spol = p;
		w(IDX_CAM1_POL, {14'h0, p, p});
		w(IDX_CAM_MODE, 16'h0000);
		w(IDX_CAP_MODE, {9'h0, sg, 6'h01});
		w(IDX_LINE_DLY, dl);
		w(IDX_PULSE_W, wd);
		w(IDX_STB_CTRL, {8'h0, cd, 2'b01, p, 1'b0});
		w(IDX_IRQ_MASK, 16'h0003);
		if (!sg) w(IDX_CAP_CMD, 16'h0004);
		for (n = 0; n < 4000 && cam.f !== 1'b1; n++) @(posedge pclk);
		tmo(n);
		for (n = 0; n < 4000 && cam.f !== 1'b0; n++) @(posedge pclk);
		tmo(n);
		wcnt = 0;
		arm = 1;
		w(IDX_CAP_CMD, sg ? 16'h0004 : 16'h0008);
		for (n = 0; n < 4000 && !sact; n++) @(posedge pclk);
		tmo(n);
		chk(dseen, dl + 1);
		if (pz)
		begin
			run = 0;
			repeat (100) @(posedge pclk);
			chk(sact, 1);
			run = 1;
		end
		for (n = 0; n < 4000 && sact; n++) @(posedge pclk);
		tmo(n);
		chk(wcnt, wd ? wd : 1);
		repeat (2) @(posedge pclk);
		chk(irq, 1);
		w(IDX_IRQ_MASK, 16'h0001);
		repeat (2) @(posedge pclk);
		chk(irq, 0);
		r(IDX_IRQ_STAT, 16'h0002);
		for (n = 0; n < 4000 && irq !== 1'b1; n++) @(posedge pclk);
		tmo(n);
		r(IDX_IRQ_STAT, 16'h0001);
		chk(ncap, sg ? 1 : cd + 1);
		r(IDX_CAP_CMD, 16'h0000);
	endtask
	initial
	begin
		repeat (8) @(posedge pclk);
		presetn <= 1;
		chk(fl, 1);
		chk(irq, 0);
		chk(cv, 0);
		foreach (regs[k]) r(regs[k], 16'h0000);
		bus(0, 16'h0001, 16'h0);
		chk(err, 1);
		chk(rd, 0);
		w(IDX_LINE_DLY, 16'ha5c3);
		r(IDX_LINE_DLY, 16'ha5c3);
		w(IDX_CAP_CMD, 16'h0008);
		w(IDX_CAP_CMD, 16'h0004);
		repeat (300) @(posedge pclk);
		chk(fl, 1);
		r(IDX_CAP_CMD, 16'h0000);
		strobe(0, 1, 16'd1, 16'd2, 4'h1, 0);
		strobe(1, 0, 16'd0, 16'd0, 4'h3, 0);
		strobe(0, 1, 16'd8, 16'd3, 4'h2, 1);
		// Align off on port 2: done on every captured frame end
		w(IDX_STB_CTRL, 16'h0002);
		w(IDX_CAM2_POL, 16'h0003);
		w(IDX_CAP_MODE, 16'h0003);
		w(IDX_IRQ_MASK, 16'h0001);
		r(IDX_IRQ_STAT, 16'h0000);
		w(IDX_CAP_CMD, 16'h0004);
		r(IDX_CAP_CMD, 16'h0001);
		repeat (2)
		begin
			for (nw = 0; nw < 4000 && irq !== 1'b1; nw++)
				@(posedge pclk);
			tmo(nw);
			r(IDX_IRQ_STAT, 16'h0001);
			repeat (2) @(posedge pclk);
		end
		r(IDX_CAP_CMD, 16'h0001);
		chk(fl, 0);
		w(IDX_CAP_MODE, 16'h0000);
		r(IDX_CAP_CMD, 16'h0000);
		complete_run;
	end
endmodule
